// >>> edge_trim_pkg.sv
// Constants and types for the four-edge trim block.
// Assumes a single 200 MHz clock and a 32-bit classic Wishbone register bus.
`default_nettype none

package edge_trim_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned STEP_PS = 5000;
	localparam int unsigned STEP_CYCLES = (STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned MAX_CODE = 7;
	localparam int unsigned MAX_SHIFT_CYCLES = MAX_CODE * STEP_CYCLES;
	// Input to output latency of an untrimmed edge.
	localparam int unsigned NOMINAL_LATENCY = MAX_SHIFT_CYCLES + 2;
	localparam int unsigned HIST_DEPTH = 2 * MAX_SHIFT_CYCLES + 1;
	localparam int unsigned TAP_W = $clog2(HIST_DEPTH);

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] FIVE_SIX_IDX = 8'h6B;
	localparam logic [7:0] SEVEN_EIGHT_IDX = 8'h6C;
	localparam int unsigned ADDR_SCALE = 4;
	localparam logic [7:0] TRIM_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Field layout of a trim register
	// ----------------------------------------------------------------
	localparam int unsigned POL_HI_BIT = 7;
	localparam int unsigned CODE_HI_MSB = 6;
	localparam int unsigned CODE_HI_LSB = 4;
	localparam int unsigned POL_LO_BIT = 3;
	localparam int unsigned CODE_LO_MSB = 2;
	localparam int unsigned CODE_LO_LSB = 0;
	localparam int unsigned NUM_EDGES = 4;

	// One edge's trim setting: sign and offset code.
	typedef struct packed {
		logic neg;
		logic [2:0] code;
	} edge_trim_t;

endpackage

`default_nettype wire

// >>> edge_trim.sv
// Dead-time trim for PWM edges five to eight, with its two trim registers.
// Assumes nominal edge pulses from on-chip logic on clk_i and a classic Wishbone master.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Register 0x6B: bit7 edge-five sign, 6:4 its code, bit3 edge-six sign, 2:0 code.
// - Register 0x6C: bit7 edge-seven sign, 6:4 its code, bit3 edge-eight sign, 2:0 code.
// - Sign bit clear means positive shift, set means negative shift.
// - Each code step moves the edge 5 ns; code seven gives 35 ns.
// - Code zero leaves the edge at nominal timing whatever the sign.
module edge_trim
	import edge_trim_pkg::*;
#(
	parameter int unsigned ADDR_W = 12
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [NUM_EDGES-1:0] edge_nominal_i,
	output logic [NUM_EDGES-1:0] edge_trimmed_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] FIVE_SIX_ADDR = ADDR_W'(int'(FIVE_SIX_IDX) * ADDR_SCALE);
	localparam logic [ADDR_W-1:0] SEVEN_EIGHT_ADDR = ADDR_W'(int'(SEVEN_EIGHT_IDX) * ADDR_SCALE);

	// Upper edge of a trim register.
	function automatic edge_trim_t hi_field(input logic [7:0] r);
		edge_trim_t t;
		t.neg = r[POL_HI_BIT];
		t.code = r[CODE_HI_MSB:CODE_HI_LSB];
		return t;
	endfunction

	// Lower edge of a trim register.
	function automatic edge_trim_t lo_field(input logic [7:0] r);
		edge_trim_t t;
		t.neg = r[POL_LO_BIT];
		t.code = r[CODE_LO_MSB:CODE_LO_LSB];
		return t;
	endfunction

	// History tap for a setting; the centre tap is the nominal position.
	function automatic logic [TAP_W-1:0] tap_of(input edge_trim_t t);
		int sh;
		sh = int'(t.code) * int'(STEP_CYCLES);
		if (t.neg)
			return TAP_W'(int'(MAX_SHIFT_CYCLES) - sh);
		else
			return TAP_W'(int'(MAX_SHIFT_CYCLES) + sh);
	endfunction

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic [7:0] five_six_trim;
	logic [7:0] seven_eight_trim;
	logic [7:0] next_five_six_trim;
	logic [7:0] next_seven_eight_trim;
	logic [31:0] next_dat;
	logic next_ack;
	logic req;

	// A request is answered one cycle later; the dropped ack keeps a held request single.
	always_comb
	begin
		req = wb_cyc_i && wb_stb_i && !wb_ack_o;
		next_ack = req;
		next_five_six_trim = five_six_trim;
		next_seven_eight_trim = seven_eight_trim;
		next_dat = 32'h0000_0000;
		if (req && wb_adr_i == FIVE_SIX_ADDR)
		begin
			next_dat = {24'h00_0000, five_six_trim};
			if (wb_we_i && wb_sel_i[0])
				next_five_six_trim = wb_dat_i[7:0];
		end
		else if (req && wb_adr_i == SEVEN_EIGHT_ADDR)
		begin
			next_dat = {24'h00_0000, seven_eight_trim};
			if (wb_we_i && wb_sel_i[0])
				next_seven_eight_trim = wb_dat_i[7:0];
		end
	end

	// Unmapped addresses are acknowledged and read as zero so the bus never hangs.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			five_six_trim <= TRIM_RESET;
			seven_eight_trim <= TRIM_RESET;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			five_six_trim <= next_five_six_trim;
			seven_eight_trim <= next_seven_eight_trim;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
		end
	end

	// ----------------------------------------------------------------
	// Edge trim
	// ----------------------------------------------------------------
	edge_trim_t trims [NUM_EDGES];
	logic [HIST_DEPTH-1:0] hist [NUM_EDGES];
	logic [HIST_DEPTH-1:0] next_hist [NUM_EDGES];
	logic [NUM_EDGES-1:0] next_edge;

	// Edge order is five, six, seven, eight.
	always_comb
	begin
		trims[0] = hi_field(five_six_trim);
		trims[1] = lo_field(five_six_trim);
		trims[2] = hi_field(seven_eight_trim);
		trims[3] = lo_field(seven_eight_trim);
	end

	// An advance cannot be made causally, so every edge is held back by the full
	// 35 ns range and the tap is chosen either side of that centre.
	always_comb
	begin
		for (int i = 0; i < NUM_EDGES; i++)
		begin
			next_hist[i] = {hist[i][HIST_DEPTH-2:0], edge_nominal_i[i]};
			next_edge[i] = hist[i][tap_of(trims[i])];
		end
	end

	// The history is cleared on reset so no stale edge leaks out afterwards.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < NUM_EDGES; i++)
				hist[i] <= '0;
			edge_trimmed_o <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_EDGES; i++)
				hist[i] <= next_hist[i];
			edge_trimmed_o <= next_edge;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [4:0] warm;
	logic warm_full;

	// Counts cycles since reset so that deep history checks start clean.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			warm <= 5'h00;
		else if (warm != 5'h1F)
			warm <= warm + 5'h01;
	end
	assign warm_full = (warm == 5'h1F);

	property p_ack_once;
		@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");

	property p_five_six_fields;
		@(posedge clk_i) disable iff (rst_i)
		(req && wb_we_i && wb_sel_i[0] && wb_adr_i == FIVE_SIX_ADDR) |=>
			trims[0].neg == $past(wb_dat_i[7]) && trims[0].code == $past(wb_dat_i[6:4])
			&& trims[1].neg == $past(wb_dat_i[3]) && trims[1].code == $past(wb_dat_i[2:0]);
	endproperty
	a_five_six_fields: assert property (p_five_six_fields) else $error("edge five/six fields wrong");

	property p_seven_eight_fields;
		@(posedge clk_i) disable iff (rst_i)
		(req && wb_we_i && wb_sel_i[0] && wb_adr_i == SEVEN_EIGHT_ADDR) |=>
			trims[2].neg == $past(wb_dat_i[7]) && trims[2].code == $past(wb_dat_i[6:4])
			&& trims[3].neg == $past(wb_dat_i[3]) && trims[3].code == $past(wb_dat_i[2:0]);
	endproperty
	a_seven_eight_fields: assert property (p_seven_eight_fields) else $error("edge seven/eight fields wrong");

	property p_zero_code_nominal;
		@(posedge clk_i) disable iff (rst_i)
		(warm_full && five_six_trim[6:4] == 3'h0 && $past(five_six_trim[6:4], 9) == 3'h0)
			|-> edge_trimmed_o[0] == $past(edge_nominal_i[0], 9);
	endproperty
	a_zero_code_nominal: assert property (p_zero_code_nominal) else $error("code zero not nominal");

	property p_full_delay;
		@(posedge clk_i) disable iff (rst_i)
		(warm_full && five_six_trim[7:4] == 4'h7 && $past(five_six_trim[7:4], 16) == 4'h7)
			|-> edge_trimmed_o[0] == $past(edge_nominal_i[0], 16);
	endproperty
	a_full_delay: assert property (p_full_delay) else $error("35 ns delay wrong");

	property p_full_advance;
		@(posedge clk_i) disable iff (rst_i)
		(warm_full && five_six_trim[3:0] == 4'hF && $past(five_six_trim[3:0], 2) == 4'hF)
			|-> edge_trimmed_o[1] == $past(edge_nominal_i[1], 2);
	endproperty
	a_full_advance: assert property (p_full_advance) else $error("35 ns advance wrong");

	property p_negative_sign;
		@(posedge clk_i) disable iff (rst_i)
		(warm_full && seven_eight_trim[7:4] == 4'hA && $past(seven_eight_trim[7:4], 7) == 4'hA)
			|-> edge_trimmed_o[2] == $past(edge_nominal_i[2], 7);
	endproperty
	a_negative_sign: assert property (p_negative_sign) else $error("set sign did not advance");

	property p_positive_sign;
		@(posedge clk_i) disable iff (rst_i)
		(warm_full && seven_eight_trim[3:0] == 4'h2 && $past(seven_eight_trim[3:0], 11) == 4'h2)
			|-> edge_trimmed_o[3] == $past(edge_nominal_i[3], 11);
	endproperty
	a_positive_sign: assert property (p_positive_sign) else $error("clear sign did not delay");

	// ----------------------------------------------------------------
	// Further bus and trim checks
	// ----------------------------------------------------------------
	// Read data must be zero outside the acknowledge cycle, so a stale word never leaks.
	property p_dat_idle;
		@(posedge clk_i) disable iff (rst_i)
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data not zero while idle");

	// A write with byte lane zero disabled must leave both registers alone.
	property p_no_write_without_sel;
		@(posedge clk_i) disable iff (rst_i)
		(req && wb_we_i && !wb_sel_i[0]) |=> $stable(five_six_trim) && $stable(seven_eight_trim);
	endproperty
	a_no_write_without_sel: assert property (p_no_write_without_sel) else $error("masked write changed a register");

	// A read of the first register returns its contents in the low byte.
	property p_read_five_six;
		@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == FIVE_SIX_ADDR) |=> wb_dat_o == {24'h00_0000, $past(five_six_trim)};
	endproperty
	a_read_five_six: assert property (p_read_five_six) else $error("edge five/six read back wrong");

	// A read of the second register returns its contents in the low byte.
	property p_read_seven_eight;
		@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i == SEVEN_EIGHT_ADDR) |=> wb_dat_o == {24'h00_0000, $past(seven_eight_trim)};
	endproperty
	a_read_seven_eight: assert property (p_read_seven_eight) else $error("edge seven/eight read back wrong");

	// Unmapped addresses read as zero, so software sees no alias of a trim register.
	property p_unmapped_zero;
		@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && wb_adr_i != FIVE_SIX_ADDR && wb_adr_i != SEVEN_EIGHT_ADDR) |=> wb_dat_o == 32'h0;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

	// An acknowledge is only ever the answer to a taken request.
	property p_ack_needs_req;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> $past(req);
	endproperty
	a_ack_needs_req: assert property (p_ack_needs_req) else $error("ack without request");

	// Code zero with the sign set must still give the nominal timing.
	property p_zero_code_negative;
		@(posedge clk_i) disable iff (rst_i)
		(warm_full && five_six_trim[3:0] == 4'h8 && $past(five_six_trim[3:0], 9) == 4'h8)
			|-> edge_trimmed_o[1] == $past(edge_nominal_i[1], 9);
	endproperty
	a_zero_code_negative: assert property (p_zero_code_negative) else $error("signed code zero not nominal");

	// Edge eight at code zero, whatever its sign, sits at the nominal timing.
	property p_zero_code_eight;
		@(posedge clk_i) disable iff (rst_i)
		(warm_full && seven_eight_trim[2:0] == 3'h0 && $past(seven_eight_trim[2:0], 9) == 3'h0)
			|-> edge_trimmed_o[3] == $past(edge_nominal_i[3], 9);
	endproperty
	a_zero_code_eight: assert property (p_zero_code_eight) else $error("edge eight code zero not nominal");

	// Edge seven delayed by three steps lands three cycles after nominal.
	property p_seven_delay;
		@(posedge clk_i) disable iff (rst_i)
		(warm_full && seven_eight_trim[7:4] == 4'h3 && $past(seven_eight_trim[7:4], 12) == 4'h3)
			|-> edge_trimmed_o[2] == $past(edge_nominal_i[2], 12);
	endproperty
	a_seven_delay: assert property (p_seven_delay) else $error("edge seven delay wrong");

endmodule

`default_nettype wire

// >>> edge_trim_tb_top.sv
// Self-checking bench for the four-edge trim block and its two trim registers.
// Assumes one 200 MHz clock, synchronous reset and the registered bus answer that the block gives.
`timescale 1ns/10ps
`default_nettype none
module edge_trim_tb_top;
	import edge_trim_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] got;
	logic ack;
	logic [3:0] nom = 4'h0;
	logic [3:0] trimmed;
	int num_errors = 0;
	int checks_done = 0;

	// Free-running clock with a 5 ns period.
	always #2.5 clk_i = ~clk_i;

	edge_trim edge_trim_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.edge_nominal_i(nom), .edge_trimmed_o(trimmed));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	// Compare with case inequality so an unknown never passes.
	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		checks_done++;
		if (seen !== expv)
		begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One classic cycle; the request is held until ack is sampled, with a bound on the wait.
	task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		got = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 20)
		begin
			num_errors++;
			stop_test();
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Reset values, field placement, a write without byte enable and an unmapped address.
	task automatic reg_scenario();
		bus(1'b0, 12'h1AC, 4'h1, 32'h0);
		check(got, 32'h0);
		bus(1'b0, 12'h1B0, 4'h1, 32'h0);
		check(got, 32'h0);
		bus(1'b1, 12'h1AC, 4'hF, 32'hFFFF_FFA5);
		bus(1'b1, 12'h1B0, 4'hF, 32'h5A);
		bus(1'b0, 12'h1AC, 4'hF, 32'h0);
		check(got, 32'hA5);
		bus(1'b1, 12'h1AC, 4'h0, 32'h33);
		bus(1'b1, 12'h1B4, 4'hF, 32'h77);
		bus(1'b0, 12'h1AC, 4'hF, 32'h0);
		check(got, 32'hA5);
		bus(1'b0, 12'h1B4, 4'hF, 32'h0);
		check(got, 32'h0);
		bus(1'b0, 12'h1B0, 4'hF, 32'h0);
		check(got, 32'h5A);
	endtask

	// Every code with both signs, a different trim on each edge, all four pulsed together.
	task automatic trim_scenario();
		logic [2:0] c [4];
		logic ng [4];
		int lat [4];
		int width [4];
		for (int s = 0; s < 2; s++)
		begin
			for (int v = 0; v < 8; v++)
			begin
				for (int i = 0; i < 4; i++)
				begin
					c[i] = 3'(v + 2 * i);
					ng[i] = 1'(s ^ i);
					lat[i] = 0;
					width[i] = 0;
				end
				bus(1'b1, 12'h1AC, 4'h1, {24'h0, ng[0], c[0], ng[1], c[1]});
				bus(1'b1, 12'h1B0, 4'h1, {24'h0, ng[2], c[2], ng[3], c[3]});
				@(posedge clk_i);
				nom <= 4'hF;
				@(posedge clk_i);
				nom <= 4'h0;
				#1;
				// Count from the edge that sampled the pulse; 20 cycles outlast the longest delay.
				for (int n = 1; n <= 20; n++)
				begin
					for (int i = 0; i < 4; i++)
					begin
						if (trimmed[i] === 1'b1)
						begin
							if (width[i] == 0)
								lat[i] = n;
							width[i]++;
						end
					end
					@(posedge clk_i);
					#1;
				end
				for (int i = 0; i < 4; i++)
				begin
					check(32'(lat[i]), ng[i] ? 32'(9 - c[i]) : 32'(9 + c[i]));
					check(32'(width[i]), 32'h1);
				end
			end
		end
	endtask

	// Reset for 12 cycles, then the scenarios and the verdict.
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		reg_scenario();
		trim_scenario();
		stop_test();
	end
endmodule
`default_nettype wire
